/* pkg/radio_cfg_pkg.sv */
package radio_cfg_pkg;

   // =====================================================================
   // timing
   // =====================================================================
   localparam int CLK_PERIOD_PS  = 25000;
   localparam int PA_LEAD_US     = 5;
   localparam int PA_LEAD_CYCLES =
      (PA_LEAD_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int CAL_US         = 256;
   localparam int CAL_CYCLES     = CAL_US * 1000000 / CLK_PERIOD_PS;
   localparam int STROBE_HIGH_NS = 100;
   localparam int STROBE_HIGH_CYCLES =
      (STROBE_HIGH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

   // =====================================================================
   // serial word layout
   // =====================================================================
   localparam int WORD_W = 16;
   localparam int DATA_W = 14;
   localparam int ADDR_W = 2;
   localparam int BIT_CNT_W = 4;

   localparam logic [ADDR_W-1:0] REG_PLL_CFG = 2'h0;
   localparam logic [ADDR_W-1:0] REG_CHANNEL = 2'h1;
   localparam logic [ADDR_W-1:0] REG_TEST    = 2'h2;

   localparam logic [DATA_W-1:0] PLL_CFG_RESET = 14'h0000;
   localparam logic [DATA_W-1:0] CHANNEL_RESET = 14'h0000;
   localparam logic [DATA_W-1:0] TEST_RESET    = 14'h0000;

   // fields of the pll configuration word
   localparam int CFG_REF_HALF_BIT = 0;
   localparam int CFG_TDD_BIT      = 1;

   // =====================================================================
   // modes
   // =====================================================================
   typedef enum logic [1:0] {MODE_STANDBY, MODE_RECEIVE, MODE_TRANSMIT} radio_mode_t;

   function automatic logic [WORD_W-1:0] pack_word(
      input logic [ADDR_W-1:0] addr,
      input logic [DATA_W-1:0] data
   );
      pack_word = {data, addr};
   endfunction

   function automatic radio_mode_t decode_mode(
      input logic enable,
      input logic rx_sel
   );
      if (!enable)
         decode_mode = MODE_STANDBY;
      else if (rx_sel)
         decode_mode = MODE_RECEIVE;
      else
         decode_mode = MODE_TRANSMIT;
   endfunction

endpackage

/* pkg/radio_link_if.sv */
`timescale 1ns/1ps
interface radio_link_if;
   logic transceiver_enable;
   logic receive_select;
   logic pa_enable_out;
   logic ser_strobe;
   logic ser_data;
   logic ser_clk;

   modport device (
      input  transceiver_enable,
      input  receive_select,
      output pa_enable_out,
      input  ser_strobe,
      input  ser_data,
      input  ser_clk
   );

   modport host (
      output transceiver_enable,
      output receive_select,
      input  pa_enable_out,
      output ser_strobe,
      output ser_data,
      output ser_clk
   );
endinterface

/* core/radio_ctrl_device.sv */
`timescale 1ns/1ps
// Overview of operation
// - enable low standby; else select picks rx/tx
// - select change repowers and reroutes signal paths
// - pa enable rises once tx rf present
// - pa enable drops 5us before rf removal
// - pa enable held off without pll lock
// - strobe rise loads word into addressed register
// - strobe high: serial clock and data ignored
// - strobe low: data sampled on clock rise
// - host sends 16-bit words with 2-bit address
// - tdd use shifts lo on rx/tx switch
// - channel register 1 writable at any time
// - reference 6.144 or 12.288 MHz drives synthesizer
// - host waits for lock and alignment; radio_ctrl_host has no lock input and does not wait
// - msb first, 14 data then 2 address
// - enable rise starts calibration within 256us
// - configuration registers are write only
// - registers kept and writable in standby
module radio_ctrl_device #(
   parameter int CAL_LEN = radio_cfg_pkg::CAL_CYCLES
) (
   // clock and reset
   input  wire logic                              I_CLK,
   input  wire logic                              I_RST_N,
   // link to host
   radio_link_if.device                           link,
   // synthesizer status
   input  wire logic                              i_PLL_LOCK,
   // mode and path control
   output radio_cfg_pkg::radio_mode_t             o_MODE,
   output logic                                   o_RX_PATH_ON,
   output logic                                   o_TX_PATH_ON,
   output logic                                   o_PATH_SWITCH,
   output logic                                   o_TX_RF_ON,
   output logic                                   o_LO_SHIFT,
   output logic                                   o_CAL_BUSY,
   // configuration
   output logic                                   o_REF_HALF_RATE,
   output logic [radio_cfg_pkg::DATA_W-1:0]       o_PLL_CFG,
   output logic [radio_cfg_pkg::DATA_W-1:0]       o_CHANNEL,
   output logic [radio_cfg_pkg::DATA_W-1:0]       o_TEST_CFG
);

   localparam int CAL_W  = $clog2(CAL_LEN + 1);
   localparam int LEAD_W = $clog2(radio_cfg_pkg::PA_LEAD_CYCLES + 1);
   localparam logic [CAL_W-1:0]  CAL_LAST  = CAL_W'(CAL_LEN - 1);
   // counter starts on the edge that drops pa, so rf falls a full lead later
   localparam logic [LEAD_W-1:0] LEAD_LAST = LEAD_W'(radio_cfg_pkg::PA_LEAD_CYCLES);

   // =====================================================================
   // serial shifter, link clock domain
   // =====================================================================
   logic [radio_cfg_pkg::WORD_W-1:0] shift;

   always_ff @(posedge link.ser_clk)
   begin
      if (!link.ser_strobe)
         shift <= {shift[radio_cfg_pkg::WORD_W-2:0], link.ser_data};
   end

   // =====================================================================
   // pin synchronisers
   // =====================================================================
   logic [1:0] en_sync;
   logic [1:0] sel_sync;
   logic [1:0] lock_sync;
   logic [1:0] strobe_sync;
   logic       strobe_prev;
   logic       en_prev;
   logic       sel_prev;

   always_ff @(posedge I_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         en_sync     <= 2'h0;
         sel_sync    <= 2'h0;
         lock_sync   <= 2'h0;
         strobe_sync <= 2'h3;
         strobe_prev <= 1'b1;
         en_prev     <= 1'b0;
         sel_prev    <= 1'b0;
      end
      else
      begin
         en_sync     <= {en_sync[0], link.transceiver_enable};
         sel_sync    <= {sel_sync[0], link.receive_select};
         lock_sync   <= {lock_sync[0], i_PLL_LOCK};
         strobe_sync <= {strobe_sync[0], link.ser_strobe};
         strobe_prev <= strobe_sync[1];
         en_prev     <= en_sync[1];
         sel_prev    <= sel_sync[1];
      end
   end

   logic load_now;
   logic en_rise;
   logic sel_change;
   logic lock;
   radio_cfg_pkg::radio_mode_t next_mode;

   assign load_now   = strobe_sync[1] && !strobe_prev;
   assign en_rise    = en_sync[1] && !en_prev;
   assign sel_change = sel_sync[1] != sel_prev;
   assign lock       = lock_sync[1];
   assign next_mode  = radio_cfg_pkg::decode_mode(en_sync[1], sel_sync[1]);

   // =====================================================================
   // configuration registers, write only, independent of mode
   // =====================================================================
   // shift is stable while the strobe is high, so it is safe to take here
   always_ff @(posedge I_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         o_PLL_CFG  <= radio_cfg_pkg::PLL_CFG_RESET;
         o_CHANNEL  <= radio_cfg_pkg::CHANNEL_RESET;
         o_TEST_CFG <= radio_cfg_pkg::TEST_RESET;
      end
      else if (load_now)
      begin
         unique case (shift[radio_cfg_pkg::ADDR_W-1:0])
            radio_cfg_pkg::REG_PLL_CFG:
               o_PLL_CFG <= shift[radio_cfg_pkg::WORD_W-1:radio_cfg_pkg::ADDR_W];
            radio_cfg_pkg::REG_CHANNEL:
               o_CHANNEL <= shift[radio_cfg_pkg::WORD_W-1:radio_cfg_pkg::ADDR_W];
            radio_cfg_pkg::REG_TEST:
               o_TEST_CFG <= shift[radio_cfg_pkg::WORD_W-1:radio_cfg_pkg::ADDR_W];
            default:
            begin
            end
         endcase
      end
   end

   always_ff @(posedge I_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
         o_REF_HALF_RATE <= 1'b0;
      else
         o_REF_HALF_RATE <= o_PLL_CFG[radio_cfg_pkg::CFG_REF_HALF_BIT];
   end

   // =====================================================================
   // mode and signal paths
   // =====================================================================
   always_ff @(posedge I_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         o_MODE        <= radio_cfg_pkg::MODE_STANDBY;
         o_RX_PATH_ON  <= 1'b0;
         o_TX_PATH_ON  <= 1'b0;
         o_PATH_SWITCH <= 1'b0;
      end
      else
      begin
         o_MODE        <= next_mode;
         o_RX_PATH_ON  <= next_mode == radio_cfg_pkg::MODE_RECEIVE;
         o_TX_PATH_ON  <= next_mode == radio_cfg_pkg::MODE_TRANSMIT;
         o_PATH_SWITCH <= sel_change && en_sync[1];
      end
   end

   // lo offset by the second if while transmitting in single-carrier tdd
   always_ff @(posedge I_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
         o_LO_SHIFT <= 1'b0;
      else
         o_LO_SHIFT <= o_PLL_CFG[radio_cfg_pkg::CFG_TDD_BIT] &&
                       next_mode == radio_cfg_pkg::MODE_TRANSMIT;
   end

   // =====================================================================
   // filter calibration after enable
   // =====================================================================
   logic [CAL_W-1:0] cal_cnt;

   always_ff @(posedge I_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         o_CAL_BUSY <= 1'b0;
         cal_cnt    <= '0;
      end
      else if (en_rise)
      begin
         o_CAL_BUSY <= 1'b1;
         cal_cnt    <= '0;
      end
      else if (o_CAL_BUSY)
      begin
         cal_cnt <= cal_cnt + 1'b1;
         if (cal_cnt == CAL_LAST)
            o_CAL_BUSY <= 1'b0;
      end
   end

   // =====================================================================
   // transmit rf and pa enable sequencing
   // =====================================================================
   logic              pa;
   logic              want_tx;
   logic [LEAD_W-1:0] lead_cnt;

   assign want_tx = o_MODE == radio_cfg_pkg::MODE_TRANSMIT && lock;

   always_ff @(posedge I_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         o_TX_RF_ON <= 1'b0;
         lead_cnt   <= '0;
      end
      else if (want_tx)
      begin
         o_TX_RF_ON <= 1'b1;
         lead_cnt   <= '0;
      end
      else if (o_TX_RF_ON)
      begin
         lead_cnt <= lead_cnt + 1'b1;
         if (lead_cnt == LEAD_LAST)
            o_TX_RF_ON <= 1'b0;
      end
   end

   always_ff @(posedge I_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
         pa <= 1'b0;
      else if (!want_tx)
         pa <= 1'b0;
      else
         pa <= o_TX_RF_ON;
   end

   assign link.pa_enable_out = pa;

endmodule

/* core/radio_ctrl_host.sv */
`timescale 1ns/1ps
module radio_ctrl_host (
   // clock and reset
   input  wire logic                              I_CLK,
   input  wire logic                              I_RST_N,
   // link to device
   radio_link_if.host                             link,
   // mode request
   input  wire logic                              i_XCVR_ENABLE,
   input  wire logic                              i_RX_SELECT,
   // configuration write request
   input  wire logic                              i_WR_VALID,
   input  wire logic [radio_cfg_pkg::ADDR_W-1:0]  i_WR_ADDR,
   input  wire logic [radio_cfg_pkg::DATA_W-1:0]  i_WR_DATA,
   output logic                                   o_WR_READY,
   // pa status
   output logic                                   o_PA_ENABLE
);

   typedef enum {H_IDLE, H_SHIFT, H_LOAD} host_state_t;

   localparam int HOLD_W = $clog2(radio_cfg_pkg::STROBE_HIGH_CYCLES + 1);
   localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(radio_cfg_pkg::STROBE_HIGH_CYCLES - 1);

   host_state_t                             state;
   logic [radio_cfg_pkg::WORD_W-1:0]        word;
   logic [1:0]                              phase;
   logic [radio_cfg_pkg::BIT_CNT_W-1:0]     bit_cnt;
   logic [HOLD_W-1:0]                       hold;
   logic                                    strobe;
   logic                                    sdata;
   logic                                    sclk;
   logic                                    xen;
   logic                                    xsel;
   logic [1:0]                              pa_sync;

   // =====================================================================
   // control pins and pa status
   // =====================================================================
   always_ff @(posedge I_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         xen         <= 1'b0;
         xsel        <= 1'b1;
         pa_sync     <= 2'h0;
         o_PA_ENABLE <= 1'b0;
      end
      else
      begin
         xen         <= i_XCVR_ENABLE;
         xsel        <= i_RX_SELECT;
         pa_sync     <= {pa_sync[0], link.pa_enable_out};
         o_PA_ENABLE <= pa_sync[1];
      end
   end

   // =====================================================================
   // serial writer, bus clock is I_CLK divided by four
   // =====================================================================
   always_ff @(posedge I_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         state      <= H_IDLE;
         word       <= '0;
         phase      <= 2'h0;
         bit_cnt    <= '0;
         hold       <= '0;
         strobe     <= 1'b1;
         sdata      <= 1'b0;
         sclk       <= 1'b0;
         o_WR_READY <= 1'b1;
      end
      else
      begin
         unique case (state)
            H_IDLE:
            begin
               if (i_WR_VALID && o_WR_READY)
               begin
                  word       <= radio_cfg_pkg::pack_word(i_WR_ADDR, i_WR_DATA);
                  strobe     <= 1'b0;
                  o_WR_READY <= 1'b0;
                  phase      <= 2'h0;
                  bit_cnt    <= '0;
                  state      <= H_SHIFT;
               end
            end
            H_SHIFT:
            begin
               phase <= phase + 2'h1;
               unique case (phase)
                  2'h0:
                  begin
                     sclk  <= 1'b0;
                     sdata <= word[radio_cfg_pkg::WORD_W-1];
                     word  <= {word[radio_cfg_pkg::WORD_W-2:0], 1'b0};
                  end
                  2'h2:
                     sclk <= 1'b1;
                  2'h3:
                  begin
                     bit_cnt <= bit_cnt + 1'b1;
                     if (&bit_cnt)
                     begin
                        state <= H_LOAD;
                        hold  <= '0;
                     end
                  end
                  default:
                  begin
                  end
               endcase
            end
            H_LOAD:
            begin
               sclk   <= 1'b0;
               strobe <= 1'b1;
               if (strobe)
               begin
                  hold <= hold + 1'b1;
                  if (hold == HOLD_LAST)
                  begin
                     state      <= H_IDLE;
                     o_WR_READY <= 1'b1;
                  end
               end
            end
         endcase
      end
   end

   assign link.transceiver_enable = xen;
   assign link.receive_select     = xsel;
   assign link.ser_strobe         = strobe;
   assign link.ser_data           = sdata;
   assign link.ser_clk            = sclk;

endmodule

/* testbench/radio_link_checker.sv */
`timescale 1ns/1ps
// =====================================================================
// link checks
module radio_link_checker (
   // clock and reset
   input  wire logic I_CLK,
   input  wire logic I_RST_N,
   // link signals
   input  wire logic transceiver_enable,
   input  wire logic receive_select,
   input  wire logic pa_enable_out,
   input  wire logic ser_strobe,
   input  wire logic ser_data,
   input  wire logic ser_clk
);
   logic       clk_q;
   logic [4:0] bits;

   default clocking cb @(posedge I_CLK);
   endclocking
   default disable iff (!I_RST_N);

   // =====================================================================
   // serial clock rises counted per frame
   always_ff @(posedge I_CLK or negedge I_RST_N)
      if (!I_RST_N)
         clk_q <= 1'b0;
      else
         clk_q <= ser_clk;

   always_ff @(posedge I_CLK or negedge I_RST_N)
      if (!I_RST_N)
         bits <= 5'h00;
      else if (ser_strobe)
         bits <= 5'h00;
      else if (ser_clk && !clk_q)
         bits <= bits + 5'h01;

   // =====================================================================
   // assertions
   AST_PA_OFF_STANDBY: assert property ((!transceiver_enable) [*6] |-> !pa_enable_out)
      else $error("pa enable high in standby");
   AST_PA_OFF_RECEIVE: assert property (receive_select [*6] |-> !pa_enable_out)
      else $error("pa enable high in receive");
   AST_PA_RISE_TX: assert property ($rose(pa_enable_out) |->
      $past(transceiver_enable, 4) && !$past(receive_select, 4))
      else $error("pa enable rose outside transmit");
   AST_PA_DROP: assert property ($rose(receive_select) |-> ##[1:6] !pa_enable_out)
      else $error("pa enable not dropped on leaving transmit");
   AST_CLK_QUIET: assert property (ser_strobe |-> !ser_clk)
      else $error("serial clock active while strobe high");
   AST_CLK_START: assert property ($fell(ser_strobe) |-> !ser_clk [*2])
      else $error("serial clock too soon after strobe fall");
   AST_DATA_HELD: assert property (ser_clk |-> $stable(ser_data))
      else $error("serial data moved around clock rise");
   AST_CLK_SHAPE: assert property ($rose(ser_clk) |=> ser_clk ##1 !ser_clk [*2])
      else $error("serial clock shape wrong");
   AST_WORD_LEN: assert property ($rose(ser_strobe) |-> bits == 5'h10)
      else $error("frame not sixteen bits");
   AST_STROBE_WIDTH: assert property ($rose(ser_strobe) |-> ser_strobe [*4])
      else $error("load strobe too short");

   cover property ($rose(pa_enable_out));
   cover property ($fell(pa_enable_out));
   cover property ($rose(ser_strobe));
endmodule

/* testbench/radio_mode_and_config_bus_tb.sv */
`timescale 1ns/1ps
// =====================================================================
// bench top
module radio_mode_and_config_bus_tb;
   localparam int CAL_LEN = 16;
   localparam int PA_LEAD = radio_cfg_pkg::PA_LEAD_CYCLES;
   logic                       clk, rst_n, lock, en, sel, wr_valid, wr_ready, pa_host;
   logic [1:0]                 wr_addr;
   logic [13:0]                wr_data, pll_cfg, channel, test_cfg;
   logic [15:0]                cap;
   logic                       rx_path, tx_path, path_sw, tx_rf, lo_shift, cal_busy, ref_half;
   radio_cfg_pkg::radio_mode_t mode;
   int                         fail_count, checks_done;

   radio_link_if link ();

   radio_ctrl_host i_radio_ctrl_host (
      .I_CLK(clk), .I_RST_N(rst_n), .link(link), .i_XCVR_ENABLE(en), .i_RX_SELECT(sel),
      .i_WR_VALID(wr_valid), .i_WR_ADDR(wr_addr), .i_WR_DATA(wr_data),
      .o_WR_READY(wr_ready), .o_PA_ENABLE(pa_host)
   );

   radio_ctrl_device #(.CAL_LEN(CAL_LEN)) i_radio_ctrl_device (
      .I_CLK(clk), .I_RST_N(rst_n), .link(link), .i_PLL_LOCK(lock), .o_MODE(mode),
      .o_RX_PATH_ON(rx_path), .o_TX_PATH_ON(tx_path), .o_PATH_SWITCH(path_sw),
      .o_TX_RF_ON(tx_rf), .o_LO_SHIFT(lo_shift), .o_CAL_BUSY(cal_busy),
      .o_REF_HALF_RATE(ref_half), .o_PLL_CFG(pll_cfg), .o_CHANNEL(channel),
      .o_TEST_CFG(test_cfg)
   );

   radio_link_checker i_radio_link_checker (
      .I_CLK(clk), .I_RST_N(rst_n), .transceiver_enable(link.transceiver_enable),
      .receive_select(link.receive_select), .pa_enable_out(link.pa_enable_out),
      .ser_strobe(link.ser_strobe), .ser_data(link.ser_data), .ser_clk(link.ser_clk)
   );

   always #12.5 clk = ~clk;

   // word as seen on the wire
   always @(posedge link.ser_clk)
      if (!link.ser_strobe)
         cap <= {cap[14:0], link.ser_data};

   // =====================================================================
   // helpers
   task chk_bit(input string name, input logic exp, input logic got);
      checks_done++;
      if (got !== exp)
      begin
         fail_count++;
         $display("Error %s expected %b seen %b", name, exp, got);
      end
   endtask

   task chk_val(input string name, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp)
      begin
         fail_count++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask

   task results();
      if (fail_count == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task cyc(input int n);
      repeat (n) @(negedge clk);
   endtask

   task wait_ready();
      int n;
      n = 0;
      while (wr_ready !== 1'b1 && n < 200)
      begin
         @(negedge clk);
         n++;
      end
   endtask

   // poke adds a refused request while busy
   task wr(input logic [1:0] a, input logic [13:0] d, input bit poke);
      wait_ready();
      wr_addr = a;
      wr_data = d;
      wr_valid = 1'b1;
      @(negedge clk);
      wr_valid = 1'b0;
      if (poke)
      begin
         @(negedge clk);
         wr_addr = 2'h2;
         wr_data = 14'h3FFF;
         wr_valid = 1'b1;
         @(negedge clk);
         wr_valid = 1'b0;
      end
      wait_ready();
      chk_bit("write_done", 1'b1, wr_ready);
      chk_val("wire_word", {d, a}, cap);
   endtask

   // =====================================================================
   // scenarios
   task t_reset();
      chk_val("mode_rst", 16'h0000, 16'(mode));
      chk_bit("pa_rst", 1'b0, link.pa_enable_out);
      chk_val("chan_rst", 16'h0000, 16'(channel));
      chk_bit("strobe_idle", 1'b1, link.ser_strobe);
   endtask

   task t_modes();
      logic [1:0] tbl [4] = '{2'b00, 2'b01, 2'b11, 2'b10};
      radio_cfg_pkg::radio_mode_t m;
      for (int i = 0; i < 4; i++)
      begin
         {en, sel} = tbl[i];
         cyc(8);
         m = !en ? radio_cfg_pkg::MODE_STANDBY :
            (sel ? radio_cfg_pkg::MODE_RECEIVE : radio_cfg_pkg::MODE_TRANSMIT);
         chk_val("mode", 16'(m), 16'(mode));
         chk_bit("rx_path", en & sel, rx_path);
         chk_bit("tx_path", en & !sel, tx_path);
         chk_bit("pa", en & !sel, link.pa_enable_out);
      end
   endtask

   task t_pa();
      int n, p;
      chk_bit("lo_tx", 1'b1, lo_shift);
      sel = 1'b1;
      n = 0;
      p = 0;
      while (link.pa_enable_out === 1'b1 && n < 20)
      begin
         @(negedge clk);
         n++;
         p += int'(path_sw === 1'b1);
      end
      n = 0;
      while (tx_rf === 1'b1 && n < 400)
      begin
         @(negedge clk);
         n++;
         p += int'(path_sw === 1'b1);
      end
      chk_val("pa_lead", 16'(PA_LEAD), 16'(n));
      chk_val("switch_pulses", 16'h0001, 16'(p));
      chk_bit("lo_rx", 1'b0, lo_shift);
      sel = 1'b0;
      n = 0;
      while (tx_rf !== 1'b1 && n < 20)
      begin
         @(negedge clk);
         n++;
      end
      chk_bit("pa_after_rf", 1'b0, link.pa_enable_out);
      cyc(1);
      chk_bit("pa_on", 1'b1, link.pa_enable_out);
   endtask

   task t_lock();
      lock = 1'b0;
      cyc(6);
      chk_bit("pa_unlocked", 1'b0, link.pa_enable_out);
      chk_bit("rf_kept", 1'b1, tx_rf);
      cyc(4);
      chk_bit("host_pa_off", 1'b0, pa_host);
      lock = 1'b1;
      cyc(10);
      chk_bit("pa_relock", 1'b1, link.pa_enable_out);
      chk_bit("host_pa_on", 1'b1, pa_host);
   endtask

   task t_writes();
      wr(2'h1, 14'h2A5C, 1'b0);
      cyc(6);
      chk_val("chan_tx", 16'h2A5C, 16'(channel));
      chk_bit("pa_kept", 1'b1, link.pa_enable_out);
      en = 1'b0;
      wr(2'h2, 14'h1234, 1'b1);
      wr(2'h1, 14'h0001, 1'b0);
      wr(2'h1, 14'h3FFE, 1'b0);
      cyc(6);
      chk_val("test_cfg", 16'h1234, 16'(test_cfg));
      chk_val("chan_stby", 16'h3FFE, 16'(channel));
      wr(2'h3, 14'h3FFF, 1'b0);
      cyc(6);
      chk_val("pll_kept", 16'h0003, 16'(pll_cfg));
      chk_val("chan_kept", 16'h3FFE, 16'(channel));
      chk_val("test_kept", 16'h1234, 16'(test_cfg));
   endtask

   task t_cal();
      int n;
      en = 1'b1;
      n = 0;
      while (cal_busy !== 1'b1 && n < 10)
      begin
         @(negedge clk);
         n++;
      end
      n = 0;
      while (cal_busy === 1'b1 && n < 100)
      begin
         @(negedge clk);
         n++;
      end
      chk_val("cal_len", 16'(CAL_LEN), 16'(n));
   endtask

   // =====================================================================
   // main sequence and watchdog
   initial
   begin
      clk = 1'b0;
      rst_n = 1'b0;
      lock = 1'b1;
      en = 1'b0;
      sel = 1'b1;
      wr_valid = 1'b0;
      wr_addr = 2'h0;
      wr_data = 14'h0000;
      cap = 16'h0000;
      fail_count = 0;
      checks_done = 0;
      cyc(6);
      rst_n = 1'b1;
      cyc(2);
      t_reset();
      wr(2'h0, 14'h0003, 1'b0);
      cyc(6);
      chk_bit("ref_half", 1'b1, ref_half);
      t_modes();
      t_pa();
      t_lock();
      t_writes();
      t_cal();
      results();
   end

   initial
   begin
      repeat (20000) @(posedge clk);
      fail_count++;
      results();
   end
endmodule
